//--- design/sfr_access_pkg.sv
`default_nettype none
package sfr_access_pkg;

	// ==========================================
	// register offsets and layouts
	localparam logic [7:0] page_select_addr = 8'h91;
	localparam logic [7:0] unlock_key_addr  = 8'hc7;
	localparam logic [7:0] page_select_rst  = 8'h00;
	localparam int         page_lsb         = 0;
	localparam int         page_msb         = 1;
	localparam logic [1:0] bank0            = 2'h0;
	localparam logic [1:0] bank1            = 2'h1;
	localparam logic [1:0] bank2            = 2'h2;

	// ==========================================
	// unlock key values
	localparam logic [7:0] key_first  = 8'haa;
	localparam logic [7:0] key_second = 8'h55;

	// ==========================================
	// timing, in clock cycles of the core clock
	localparam int         key_wait_cycles = 3;
	localparam int         window_cycles   = 4;
	localparam logic [2:0] key_wait_cnt    = 3'(key_wait_cycles);
	localparam logic [2:0] window_cnt      = 3'(window_cycles);

	// ==========================================
	// unlock sequencer states
	typedef enum logic [1:0] {
		st_idle   = 2'b00,
		st_waiting = 2'b01,
		st_open   = 2'b10
	} unlock_state_t;

	// ==========================================
	// core register access request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// ==========================================
	// whole state of the unlock sequencer
	typedef struct packed {
		unlock_state_t state;
		logic [2:0]    count;
	} unlock_regs_t;

	// ==========================================
	// whole state of the page and read path
	typedef struct packed {
		logic [1:0] page;
		logic [7:0] rdata;
		logic       rvalid;
	} top_regs_t;

endpackage

`default_nettype wire

//--- design/timed_unlock.sv
`timescale 1ns/1ps
`default_nettype none

module timed_unlock (
	input  wire logic i_sys_clk,
	input  wire logic i_arst_n,
	input  wire logic i_key_wr,
	input  wire logic [7:0] i_key_data,
	output logic      o_window_open
);

	sfr_access_pkg::unlock_regs_t r;
	sfr_access_pkg::unlock_regs_t next_r;

	// ==========================================
	// key sequence and window counter
	always_comb begin
		next_r = r;
		case (r.state)
			sfr_access_pkg::st_idle: begin
			end
			sfr_access_pkg::st_waiting: begin
				if (r.count == 3'h1) begin
					next_r.state = sfr_access_pkg::st_idle; // too late, no window
				end
				next_r.count = r.count - 3'h1;
			end
			sfr_access_pkg::st_open: begin
				if (r.count == 3'h1) begin
					next_r.state = sfr_access_pkg::st_idle; // self close
				end
				next_r.count = r.count - 3'h1;
			end
			default: begin
				next_r.state = sfr_access_pkg::st_idle;
			end
		endcase
		// key writes only steer the sequencer
		if (i_key_wr) begin
			if (i_key_data == sfr_access_pkg::key_first) begin
				next_r.state = sfr_access_pkg::st_waiting; // restart wait
				next_r.count = sfr_access_pkg::key_wait_cnt;
			end else if (i_key_data == sfr_access_pkg::key_second
				&& r.state == sfr_access_pkg::st_waiting) begin
				next_r.state = sfr_access_pkg::st_open; // open window
				next_r.count = sfr_access_pkg::window_cnt;
			end else begin
				next_r.state = sfr_access_pkg::st_idle; // wrong key aborts
				next_r.count = 3'h0;
			end
		end
		if (next_r.state == sfr_access_pkg::st_idle) begin
			next_r.count = 3'h0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r <= '{state: sfr_access_pkg::st_idle, count: 3'h0};
		end else begin
			r <= next_r;
		end
	end

	// window qualifier, level
	assign o_window_open = (r.state == sfr_access_pkg::st_open);

endmodule

`default_nettype wire

//--- design/sfr_page_and_timed_unlock.sv
`timescale 1ns/1ps
`default_nettype none

module sfr_page_and_timed_unlock (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_arst_n,
	// core register strobes
	input  wire logic       i_sfr_wr,
	input  wire logic       i_sfr_rd,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic [7:0] i_sfr_wdata,
	// protected register select, decoded outside
	input  wire logic       i_prot_sel,
	// read answer
	output logic      [7:0] o_sfr_rdata,
	output logic            o_sfr_rvalid,
	// steering and unlock status
	output logic            o_sfr_hit,
	output logic      [1:0] o_bank_sel,
	output logic            o_window_open,
	output logic            o_prot_wr_en
);

	sfr_access_pkg::sfr_req_t  req;
	sfr_access_pkg::top_regs_t r;
	sfr_access_pkg::top_regs_t next_r;
	logic                      page_hit;
	logic                      key_hit;
	logic                      any_hit;
	logic                      page_wr;
	logic                      key_wr;
	logic                      page_rd;
	logic                      key_rd;
	logic [1:0]                next_page;
	logic                      read_valid;
	logic [7:0]                read_data;
	logic                      window_open;

	// ==========================================
	// usage notes
	// both registers answer on every bank
	// page value 3 is stored but steers nowhere
	// bits 7:2 of the page byte read back as zero
	// key register never returns its contents
	// key reads still give a valid pulse
	// key pair must arrive close together
	// masked interrupts keep the pair tight
	// interrupt code saves and restores the page
	// window lasts a fixed count, not a write count
	// several protected writes may share a window
	// a late protected write is silently dropped
	// fresh first key closes an open window
	// any other key value aborts the sequence
	// second key outside the wait aborts too
	// write enable is combinational; sample mid-cycle
	// protected reads are never gated here

	// ==========================================
	// unlock timing, edge by edge
	// edge k:   first key taken, wait count 3
	// edge k+1: second key here opens the window
	// edge k+2: still accepted
	// edge k+3: last edge that opens the window
	// edge k+4: wait expired, second key refused
	// opening edge j: window high from j to j+4
	// protected write taken at j+1 .. j+4 lands
	// protected write at j+5 or later is dropped
	//
	// page timing
	// write taken at edge n steers from cycle n+1
	// read taken at edge n answers in cycle n+1
	// read data holds until the next read

	// ==========================================
	// request carrier
	assign req = '{
		wr:    i_sfr_wr,
		rd:    i_sfr_rd,
		addr:  i_sfr_addr,
		wdata: i_sfr_wdata
	};

	// ==========================================
	// address decode; both registers sit on every page
	always_comb begin
		page_hit = 1'b0;
		key_hit  = 1'b0;
		case (req.addr)
			sfr_access_pkg::page_select_addr: begin
				page_hit = 1'b1;
			end
			sfr_access_pkg::unlock_key_addr: begin
				key_hit = 1'b1;
			end
			default: begin
				page_hit = 1'b0;
				key_hit  = 1'b0;
			end
		endcase
	end

	// ==========================================
	// strobe qualification
	assign any_hit = page_hit || key_hit;
	assign page_wr = req.wr && page_hit;
	assign key_wr  = req.wr && key_hit; // key writes only steer the sequencer
	assign page_rd = req.rd && page_hit;
	assign key_rd  = req.rd && key_hit;

	// ==========================================
	// page path; bits 7:2 of the byte are dropped
	always_comb begin
		next_page = r.page;
		if (page_wr) begin
			next_page = req.wdata[sfr_access_pkg::page_msb:sfr_access_pkg::page_lsb];
		end
	end

	// ==========================================
	// read path; unknown addresses give zero, no valid
	always_comb begin
		read_valid = 1'b0;
		read_data  = 8'h00;
		case ({page_rd, key_rd})
			2'b10: begin
				read_valid = 1'b1;
				read_data  = {6'h00, r.page};
			end
			2'b01: begin
				read_valid = 1'b1;
				read_data  = 8'h00; // key register reads zero
			end
			default: begin
				read_valid = 1'b0;
				read_data  = 8'h00;
			end
		endcase
	end

	// ==========================================
	// key sequencer
	timed_unlock u_unlock (
		.i_sys_clk     (i_sys_clk),
		.i_arst_n      (i_arst_n),
		.i_key_wr      (key_wr),
		.i_key_data    (req.wdata),
		.o_window_open (window_open)
	);

	// ==========================================
	// next register state
	always_comb begin
		next_r        = r;
		next_r.page   = next_page;
		next_r.rvalid = read_valid;
		if (req.rd) begin
			next_r.rdata = read_data;
		end
	end

	// ==========================================
	// page register and read data
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r <= '{
				page:   sfr_access_pkg::bank0,
				rdata:  8'h00,
				rvalid: 1'b0
			};
		end else begin
			r <= next_r;
		end
	end

	// ==========================================
	// outputs
	assign o_sfr_rdata   = r.rdata;
	assign o_sfr_rvalid  = r.rvalid;
	assign o_sfr_hit     = any_hit;
	assign o_bank_sel    = r.page; // bank steering
	assign o_window_open = window_open;
	// write enable judged in the completing cycle; reads never gated
	assign o_prot_wr_en  = req.wr && i_prot_sel && window_open;

endmodule

`default_nettype wire

//--- test/sfr_page_and_timed_unlock_properties.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// port-level checks of paging and unlock
module sfr_props (
	input wire logic       i_sys_clk,
	input wire logic       i_arst_n,
	input wire logic       i_sfr_wr,
	input wire logic       i_sfr_rd,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic       i_prot_sel,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic       o_sfr_rvalid,
	input wire logic       o_sfr_hit,
	input wire logic [1:0] o_bank_sel,
	input wire logic       o_window_open,
	input wire logic       o_prot_wr_en
);
	// key writes by value
	wire logic kw  = i_sfr_wr && i_sfr_addr == 8'hc7;
	wire logic kaa = kw && i_sfr_wdata == 8'haa;
	wire logic k55 = kw && i_sfr_wdata == 8'h55;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	page_write_a: assert property (
		i_sfr_wr && i_sfr_addr == 8'h91 |=> o_bank_sel == $past(i_sfr_wdata[1:0]))
		else $error("page field not taken");
	reset_bank_a: assert property ($rose(i_arst_n) |-> o_bank_sel == 2'h0)
		else $error("bank not 0 after reset");
	key_read_a: assert property (
		i_sfr_rd && i_sfr_addr == 8'hc7 |=> o_sfr_rvalid && o_sfr_rdata == 8'h00)
		else $error("key readable");
	key_opens_a: assert property (kaa ##[1:3] k55 |=> o_window_open)
		else $error("window not opened");
	late_key_a: assert property (kaa ##1 !kw [*3] ##1 k55 |=> !o_window_open)
		else $error("late key opened window");
	window_len_a: assert property (
		$rose(o_window_open) |-> o_window_open [*4] ##1 !o_window_open)
		else $error("window length wrong");
	open_cause_a: assert property ($rose(o_window_open) |-> $past(k55))
		else $error("window opened without key");
	prot_gate_a: assert property (
		o_prot_wr_en == (i_sfr_wr && i_prot_sel && o_window_open))
		else $error("protected write gate wrong");
	hit_decode_a: assert property (
		o_sfr_hit == (i_sfr_addr == 8'h91 || i_sfr_addr == 8'hc7))
		else $error("register decode wrong");
endmodule
bind sfr_page_and_timed_unlock sfr_props i_sfr_props (.*);
`default_nettype wire

//--- test/sfr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// core side: one strobe cycle per access
module sfr_core_model (
	input  wire logic       i_sys_clk,
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_prot
);
	initial begin
		{o_wr, o_rd, o_prot, o_addr, o_wdata} = '0;
	end
	// released lines show inverted data, never stale
	task write(input logic [7:0] a, input logic [7:0] d, input logic p);
		@(negedge i_sys_clk);
		{o_wr, o_addr, o_wdata, o_prot} = {1'b1, a, d, p};
		@(negedge i_sys_clk);
		{o_wr, o_addr, o_wdata, o_prot} = {1'b0, ~a, ~d, 1'b0};
	endtask
	task read(input logic [7:0] a);
		@(negedge i_sys_clk);
		{o_rd, o_addr} = {1'b1, a};
		@(negedge i_sys_clk);
		{o_rd, o_addr} = {1'b0, ~a};
	endtask
	// key pair one idle cycle apart, nothing written in between
	task unlock;
		write(8'hc7, 8'haa, 1'b0);
		write(8'hc7, 8'h55, 1'b0);
	endtask
endmodule
`default_nettype wire

//--- test/tb_sfr_page_and_timed_unlock.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sfr_page_and_timed_unlock;
	logic       i_sys_clk = 1'b0;
	logic       i_arst_n  = 1'b0;
	logic       wr, rd, prot, rvalid, win, en;
	logic [7:0] addr, wdata, rdata;
	logic [1:0] bank;
	logic [7:0] saved;
	int         n_errors  = 0;
	int         n_tests   = 0;
	sfr_core_model i_sfr_core_model (.i_sys_clk(i_sys_clk), .o_wr(wr), .o_rd(rd),
		.o_addr(addr), .o_wdata(wdata), .o_prot(prot));
	sfr_page_and_timed_unlock i_sfr_page_and_timed_unlock (.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_addr(addr),
		.i_sfr_wdata(wdata), .i_prot_sel(prot), .o_sfr_rdata(rdata),
		.o_sfr_rvalid(rvalid), .o_sfr_hit(), .o_bank_sel(bank),
		.o_window_open(win), .o_prot_wr_en(en));
	initial begin
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0t: %h not %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task finish_test;
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		i_sfr_core_model.read(a);
		chk({7'h0, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask
	// protected write, enable sampled in its own cycle
	task pw(input logic [7:0] exp);
		fork
			i_sfr_core_model.write(8'h30, 8'h5a, 1'b1);
			begin
				@(negedge i_sys_clk);
				#1 chk({7'h0, en}, exp);
			end
		join
	endtask
	// =====
	// main sequence
	initial begin
		repeat (3) @(negedge i_sys_clk);
		i_arst_n = 1'b1;
		rdchk(8'h91, 8'h00);
		for (int b = 2; b >= 0; b--) begin
			i_sfr_core_model.write(8'h91, 8'hfc | 8'(b), 1'b0);
			chk({6'h0, bank}, 8'(b));
			rdchk(8'h91, 8'(b));
		end
		i_sfr_core_model.write(8'h91, 8'h01, 1'b0);
		i_sfr_core_model.read(8'h91);
		saved = rdata;
		i_sfr_core_model.write(8'h91, 8'h02, 1'b0);
		chk({6'h0, bank}, 8'h02);
		i_sfr_core_model.write(8'h91, saved, 1'b0);
		chk({6'h0, bank}, 8'h01);
		pw(8'h00);
		i_sfr_core_model.unlock();
		chk({7'h0, win}, 8'h01);
		pw(8'h01);
		pw(8'h01);
		pw(8'h00);
		i_sfr_core_model.write(8'hc7, 8'haa, 1'b0);
		repeat (2) @(negedge i_sys_clk);
		i_sfr_core_model.write(8'hc7, 8'h55, 1'b0);
		chk({7'h0, win}, 8'h00);
		pw(8'h00);
		rdchk(8'hc7, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
